//--- hdl/crf_consts.vh
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH
// register offsets (byte addresses on the plain register port)
`define CRF_OFS_RXB1_CTRL 8'h00
`define CRF_OFS_MASK_SEL0 8'h01
`define CRF_OFS_OPMODE 8'h02
`define CRF_OFS_TX_ENABLE 8'h03
`define CRF_OFS_EIDH_BASE 8'h10
`define CRF_OFS_EIDL_BASE 8'h18
// control register field positions
`define CRF_CTL_FULL_BIT 7
`define CRF_CTL_RXM_HI_BIT 6
`define CRF_CTL_RXM_LO_BIT 5
`define CRF_CTL_RTR_M12_BIT 5
`define CRF_CTL_RTR_M0_BIT 3
// reset values
`define CRF_RST_MASK_SEL0 8'h50
`define CRF_RST_OPMODE 2'h0
`define CRF_RST_TX_ENABLE 6'h00
// operating modes
`define CRF_MODE_LEGACY 2'h0
`define CRF_MODE_ENH 2'h1
`define CRF_MODE_FIFO 2'h2
// legacy receive-mode encodings
`define CRF_RXM_ALL 2'h3
`define CRF_RXM_EXT 2'h2
`define CRF_RXM_STD 2'h1
`define CRF_RXM_FILT 2'h0
// mask-select encodings
`define CRF_MSEL_MASK0 2'h0
`define CRF_MSEL_MASK1 2'h1
`define CRF_MSEL_FIL15 2'h2
`define CRF_MSEL_NONE 2'h3
`endif

//--- hdl/crf_mask_sel_dec.v
`timescale 1ns/1ns
`default_nettype none
`include "crf_consts.vh"
// decodes one two-bit mask-select field
module crf_mask_sel_dec
(
  // field in
  input wire [1:0] sel_i,
  // one-hot link out: mask0, mask1, filter15, none
  output wire [3:0] link_o
);
  // same four-way encoding for every filter
  assign link_o[0] = (sel_i == `CRF_MSEL_MASK0); // RULE_09
  assign link_o[1] = (sel_i == `CRF_MSEL_MASK1); // RULE_09
  assign link_o[2] = (sel_i == `CRF_MSEL_FIL15); // RULE_09
  assign link_o[3] = (sel_i == `CRF_MSEL_NONE); // RULE_09
endmodule // crf_mask_sel_dec
`default_nettype wire

//--- hdl/crf_rx_buffer_filter_select.v
// Overview of operation
// RULE_01: legacy mode, receive-mode all: take every message, errors too, no filters.
// RULE_02: legacy extended-only: accept valid extended frames; filter extended enable required.
// RULE_03: modes 1 and 2: one receive-mode bit; one means accept all.
// RULE_04: remote-request status bit, bit 5 in modes 1,2, bit 3 in mode 0.
// RULE_05: filter-hit index: three bits in mode 0, five bits in modes 1,2.
// RULE_06: extended-id byte registers exist only in modes 1 and 2.
// RULE_07: receive buffers 0-5 high byte shows id bits 15:8, read-only.
// RULE_08: low byte shows id bits 7:0, msb at bit 7.
// RULE_09: filter 3 select: 00 mask0, 01 mask1, 10 filter15, 11 none.
// RULE_10: filters 0,1,2 fields at bits 1:0, 3:2, 5:4, same coding.
// RULE_11: mask-select only in modes 1,2; reset filters 2,3 mask1, 0,1 mask0.
// RULE_12: full flag set on load; no overwrite while set; software clears.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "crf_consts.vh"
module crf_rx_buffer_filter_select
#(
  parameter NBUF = 6
)
(
  // clock and reset
  input wire clk_sys_i,
  input wire rst_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // protocol engine: received frame offer
  input wire rx_valid_i,
  input wire rx_err_i,
  input wire rx_ext_i,
  input wire rx_rtr_i,
  input wire [4:0] rx_hit_i,
  input wire rx_hit_match_i,
  input wire rx_hit_ext_en_i,
  input wire [15:0] rx_eid_i,
  // protocol engine: configurable buffer capture
  input wire cb_load_i,
  input wire [2:0] cb_idx_i,
  input wire [15:0] cb_eid_i,
  // status toward engine
  output reg rx_taken_o,
  output reg buffer_full_flag_o,
  output reg [1:0] op_mode_o,
  output reg [7:0] filter_mask_select_0_o
);
  // ******************************************************
  // state
  // ******************************************************
  reg [1:0] mode_ff;
  reg full_ff;
  reg rxm_hi_ff;
  reg rxm_lo_ff;
  reg rtr_ff;
  reg [4:0] hit_ff;
  reg [7:0] msel_ff;
  reg [NBUF-1:0] tx_en_ff;
  reg [7:0] eidh_ff [0:NBUF-1];
  reg [7:0] eidl_ff [0:NBUF-1];
  wire legacy;
  wire accept;
  wire load;
  wire [15:0] links;
  wire [7:0] msel_view;
  reg [7:0] nxt_rdata;
  reg [7:0] ctl_view;
  integer i;

  assign legacy = (mode_ff == `CRF_MODE_LEGACY);

  // ******************************************************
  // acceptance decision
  // ******************************************************
  // legacy mode uses both receive-mode bits, enhanced only the high one
  reg acc_r;
  always @*
  begin
    acc_r = 1'b0;
    if (legacy)
    begin
      case ({rxm_hi_ff, rxm_lo_ff})
        `CRF_RXM_ALL: acc_r = 1'b1; // RULE_01
        `CRF_RXM_EXT: acc_r = !rx_err_i && rx_ext_i && rx_hit_match_i
                            && rx_hit_ext_en_i; // RULE_02
        `CRF_RXM_STD: acc_r = !rx_err_i && !rx_ext_i && rx_hit_match_i;
        default: acc_r = !rx_err_i && rx_hit_match_i;
      endcase
    end
    else if (rxm_hi_ff)
    begin
      acc_r = 1'b1; // RULE_03
    end
    else
    begin
      acc_r = !rx_err_i && rx_hit_match_i; // RULE_03
    end
  end
  assign accept = acc_r;
  // a held message is never overwritten
  assign load = rx_valid_i && accept && !full_ff; // RULE_12

  // ******************************************************
  // buffer and control register
  // ******************************************************
  // set wins over a software clear in the same cycle
  wire clr_full;
  assign clr_full = reg_wr_i && (reg_addr_i == `CRF_OFS_RXB1_CTRL)
                    && !reg_wdata_i[`CRF_CTL_FULL_BIT];
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      full_ff <= 1'b0;
      rtr_ff <= 1'b0;
      hit_ff <= 5'h00;
      rxm_hi_ff <= 1'b0;
      rxm_lo_ff <= 1'b0;
      rx_taken_o <= 1'b0;
    end
    else
    begin
      rx_taken_o <= load;
      if (load)
      begin
        full_ff <= 1'b1; // RULE_12
        rtr_ff <= rx_rtr_i; // RULE_04
        hit_ff <= legacy ? {2'h0, rx_hit_i[2:0]} : rx_hit_i; // RULE_05
      end
      else if (clr_full)
      begin
        full_ff <= 1'b0; // RULE_12
      end
      if (reg_wr_i && (reg_addr_i == `CRF_OFS_RXB1_CTRL))
      begin
        rxm_hi_ff <= reg_wdata_i[`CRF_CTL_RXM_HI_BIT];
        // low mode bit only writable in legacy mode
        if (legacy)
        begin
          rxm_lo_ff <= reg_wdata_i[`CRF_CTL_RXM_LO_BIT];
        end
      end
    end
  end

  // ******************************************************
  // mode, mask select, transmit enables
  // ******************************************************
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_ff <= `CRF_RST_OPMODE;
      msel_ff <= `CRF_RST_MASK_SEL0; // RULE_11
      tx_en_ff <= {NBUF{1'b0}};
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        `CRF_OFS_OPMODE:
        begin
          if (reg_wdata_i[1:0] != 2'h3)
          begin
            mode_ff <= reg_wdata_i[1:0];
          end
        end
        `CRF_OFS_MASK_SEL0:
        begin
          if (!legacy)
          begin
            msel_ff <= reg_wdata_i; // RULE_11
          end
        end
        `CRF_OFS_TX_ENABLE: tx_en_ff <= reg_wdata_i[NBUF-1:0];
        default: ;
      endcase
    end
  end

  // ******************************************************
  // extended-id bytes of configurable buffers
  // ******************************************************
  // no reset: contents are undefined until written or captured
  always @(posedge clk_sys_i)
  begin
    for (i = 0; i < NBUF; i = i + 1)
    begin
      if (!legacy && !tx_en_ff[i] && cb_load_i && (cb_idx_i == i))
      begin
        eidh_ff[i] <= cb_eid_i[15:8]; // RULE_07
        eidl_ff[i] <= cb_eid_i[7:0]; // RULE_08
      end
      else if (!legacy && tx_en_ff[i] && reg_wr_i)
      begin
        if (reg_addr_i == (`CRF_OFS_EIDH_BASE + i))
        begin
          eidh_ff[i] <= reg_wdata_i;
        end
        if (reg_addr_i == (`CRF_OFS_EIDL_BASE + i))
        begin
          eidl_ff[i] <= reg_wdata_i;
        end
      end
    end
  end

  // ******************************************************
  // mask-select decode, one instance per filter
  // ******************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_msel
      crf_mask_sel_dec u_dec
      (
        .sel_i(msel_ff[2*g+1:2*g]), // RULE_10
        .link_o(links[4*g+3:4*g])
      );
      // readback is rebuilt from the links so a bad decode shows up
      assign msel_view[2*g+1] = links[4*g+3] | links[4*g+2]; // RULE_09
      assign msel_view[2*g] = links[4*g+3] | links[4*g+1]; // RULE_09
    end
  endgenerate

  // ******************************************************
  // read path
  // ******************************************************
  // layout of the control byte depends on mode
  always @*
  begin
    ctl_view = 8'h00;
    ctl_view[`CRF_CTL_FULL_BIT] = full_ff;
    ctl_view[`CRF_CTL_RXM_HI_BIT] = rxm_hi_ff;
    if (legacy)
    begin
      ctl_view[`CRF_CTL_RXM_LO_BIT] = rxm_lo_ff;
      ctl_view[`CRF_CTL_RTR_M0_BIT] = rtr_ff; // RULE_04
      ctl_view[2:0] = hit_ff[2:0]; // RULE_05
    end
    else
    begin
      ctl_view[`CRF_CTL_RTR_M12_BIT] = rtr_ff; // RULE_04
      ctl_view[4:0] = hit_ff; // RULE_05
    end
  end

  always @*
  begin
    nxt_rdata = 8'h00;
    case (reg_addr_i)
      `CRF_OFS_RXB1_CTRL: nxt_rdata = ctl_view;
      `CRF_OFS_MASK_SEL0: nxt_rdata = legacy ? 8'h00 : msel_view; // RULE_11
      `CRF_OFS_OPMODE: nxt_rdata = {6'h00, mode_ff};
      `CRF_OFS_TX_ENABLE: nxt_rdata = {{(8-NBUF){1'b0}}, tx_en_ff};
      default:
      begin
        // indexed by the low address bits; the loop index stays clocked-only
        if (!legacy && (reg_addr_i[2:0] < NBUF))
        begin
          if ({reg_addr_i[7:3], 3'h0} == `CRF_OFS_EIDH_BASE)
          begin
            nxt_rdata = eidh_ff[reg_addr_i[2:0]]; // RULE_06
          end
          if ({reg_addr_i[7:3], 3'h0} == `CRF_OFS_EIDL_BASE)
          begin
            nxt_rdata = eidl_ff[reg_addr_i[2:0]]; // RULE_06
          end
        end
      end
    endcase
  end

  // read data stands one cycle after the strobe, zero otherwise
  always @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
      buffer_full_flag_o <= 1'b0;
      op_mode_o <= `CRF_RST_OPMODE;
      filter_mask_select_0_o <= `CRF_RST_MASK_SEL0;
    end
    else
    begin
      reg_rdata_o <= reg_rd_i ? nxt_rdata : 8'h00;
      buffer_full_flag_o <= full_ff;
      op_mode_o <= mode_ff;
      filter_mask_select_0_o <= msel_ff;
    end
  end
endmodule // crf_rx_buffer_filter_select
`default_nettype wire

//--- bench/crf_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// port checker
// ****
module crf_assertions (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // watched ports
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic rx_valid_i,
  input wire logic rx_taken_o,
  input wire logic buffer_full_flag_o,
  input wire logic [1:0] op_mode_o,
  input wire logic [7:0] filter_mask_select_0_o
);
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // op_mode_o lags a mode write, so such cycles are left out
  wire logic m_wr = reg_wr_i && reg_addr_i == 8'h02;
  wire logic c_wr = reg_wr_i && reg_addr_i == 8'h00 && !reg_wdata_i[7];
  wire logic s_wr = reg_wr_i && reg_addr_i == 8'h01;
  wire logic [1:0] wd_lo = reg_wdata_i[1:0];
  AST_TAKE_FULL: assert property (rx_taken_o |=> buffer_full_flag_o)
    else $error("full flag not set");
  AST_TAKE_CAUSE: assert property (rx_taken_o |-> $past(rx_valid_i))
    else $error("take without offer");
  AST_FULL_REFUSE: assert property (rx_valid_i && buffer_full_flag_o
    && !$past(c_wr) |=> !rx_taken_o) else $error("overwrite while full");
  AST_FULL_CLEAR: assert property (c_wr && !rx_valid_i
    |-> ##2 !buffer_full_flag_o) else $error("full flag not cleared");
  AST_MSEL_WRITE: assert property (s_wr && op_mode_o != 2'h0 && !$past(m_wr)
    |-> ##2 filter_mask_select_0_o == $past(reg_wdata_i, 2))
    else $error("mask select not written");
  AST_MSEL_LEGACY: assert property (s_wr && op_mode_o == 2'h0 && !$past(m_wr)
    |-> ##2 $stable(filter_mask_select_0_o)) else $error("mask select in mode 0");
  AST_EID_M0: assert property (reg_rd_i && reg_addr_i[7:4] == 4'h1
    && op_mode_o == 2'h0 && !$past(m_wr) |=> reg_rdata_o == 8'h00)
    else $error("id byte seen in mode 0");
  AST_MODE_WRITE: assert property (m_wr && wd_lo != 2'h3
    |-> ##2 op_mode_o == $past(wd_lo, 2)) else $error("mode not taken");
endmodule // crf_assertions
`default_nettype wire

//--- bench/crf_engine_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// protocol engine model
// ****
module crf_engine_model (
  // clock
  input wire logic clk_i,
  // frame offer and buffer capture
  output logic ofr_o,
  output logic err_o,
  output logic ext_o,
  output logic rtr_o,
  output logic [4:0] hit_o,
  output logic match_o,
  output logic xen_o,
  output logic [15:0] eid_o,
  output logic ld_o,
  output logic [2:0] idx_o,
  output logic [15:0] ldid_o
);
  initial {ofr_o, err_o, ext_o, rtr_o, hit_o, match_o, xen_o, eid_o, ld_o,
    idx_o, ldid_o} = '0;
  // one-cycle offer; afterwards hit_o shows the inverted hit, the other lines keep their value
  task offer(input logic [8:0] f);
    @(posedge clk_i);
    ofr_o <= 1'b1;
    {err_o, ext_o, rtr_o, match_o, hit_o} <= f;
    xen_o <= 1'b1;
    eid_o <= 16'($urandom);
    @(posedge clk_i);
    ofr_o <= 1'b0;
    hit_o <= ~f[4:0];
  endtask
  // capture into one configurable buffer
  task load(input logic [2:0] n, input logic [15:0] d);
    @(posedge clk_i);
    {ld_o, idx_o, ldid_o} <= {1'b1, n, d};
    @(posedge clk_i);
    ld_o <= 1'b0;
    ldid_o <= ~d;
  endtask
endmodule // crf_engine_model
`default_nettype wire

//--- bench/test_crf_rx_buffer_filter_select.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// bench top
// ****
module test_crf_rx_buffer_filter_select;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  wire logic [7:0] reg_rdata_o, filter_mask_select_0_o;
  wire logic rx_valid_i, rx_err_i, rx_ext_i, rx_rtr_i, rx_hit_match_i;
  wire logic rx_hit_ext_en_i, cb_load_i, rx_taken_o, buffer_full_flag_o;
  wire logic [4:0] rx_hit_i;
  wire logic [15:0] rx_eid_i, cb_eid_i;
  wire logic [2:0] cb_idx_i;
  wire logic [1:0] op_mode_o;
  integer n_fail = 0, compares = 0, cyc = 0, mode, rxm, i, j;
  logic [8:0] f;
  logic [7:0] ctl, d;
  logic [15:0] extended_identifier_bits;
  logic a;
  crf_rx_buffer_filter_select i_dut (.*);
  crf_engine_model i_eng (.clk_i(clk_sys_i), .ofr_o(rx_valid_i),
    .err_o(rx_err_i), .ext_o(rx_ext_i), .rtr_o(rx_rtr_i), .hit_o(rx_hit_i),
    .match_o(rx_hit_match_i), .xen_o(rx_hit_ext_en_i), .eid_o(rx_eid_i),
    .ld_o(cb_load_i), .idx_o(cb_idx_i), .ldid_o(cb_eid_i));
  initial forever #10 clk_sys_i = ~clk_sys_i;
  // hang guard, well above the at most about 660 cycles needed
  always @(posedge clk_sys_i)
  begin
    cyc = cyc + 1;
    if (cyc == 4000)
    begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  task chk_rd(input logic [7:0] g, input logic [7:0] x);
    compares = compares + 1;
    if (g !== x)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %0t got %h want %h", $time, g, x);
    end
  endtask
  task chk_take(input logic g, input logic x);
    chk_rd({7'h0, g}, {7'h0, x});
  endtask
  task wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= dt;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] ad, input logic [7:0] x);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 chk_rd(reg_rdata_o, x);
  endtask
  // random frame; if taken, a clean second offer must bounce off
  task frame;
    f = 9'($urandom);
    if (mode == 0 && rxm[1] != rxm[0]) f[5] = 1'b1;
    if (rxm == 3 || (mode > 0 && rxm == 1)) a = 1'b1;
    else if (mode == 0 && rxm == 2) a = !f[8] && f[7];
    else if (mode == 0 && rxm == 1) a = !f[8] && !f[7];
    else a = !f[8] && f[5];
    i_eng.offer(f);
    #1 chk_take(rx_taken_o, a);
    if (a)
    begin
      i_eng.offer({1'b0, f[7:6], 1'b1, f[4:0]});
      #1 chk_take(rx_taken_o, 1'b0);
      rd(8'h00, mode == 0 ? {1'b1, rxm[1:0], 1'b0, f[6], f[2:0]}
        : {1'b1, rxm[0], f[6], f[4:0]});
      wr(8'h00, ctl);
    end
  endtask
  task complete_run;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    i = $urandom(40489);
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    #1 chk_rd(filter_mask_select_0_o, 8'h50);
    rd(8'h00, 8'h00);
    for (mode = 0; mode < 3; mode = mode + 1)
    begin
      wr(8'h02, 8'(mode));
      for (rxm = 0; rxm < (mode == 0 ? 4 : 2); rxm = rxm + 1)
      begin
        ctl = mode == 0 ? {1'b0, rxm[1:0], 5'h0} : {1'b0, rxm[0], 6'h0};
        wr(8'h00, ctl);
        repeat (8) frame;
      end
    end
    // every select code in each field, then a random mix
    for (i = 0; i < 5; i = i + 1)
    begin
      d = i < 4 ? {4{i[1:0]}} : 8'($urandom);
      wr(8'h01, d);
      rd(8'h01, d);
    end
    for (j = 0; j < 6; j = j + 1)
    begin
      extended_identifier_bits = 16'($urandom);
      i_eng.load(3'(j), extended_identifier_bits);
      rd(8'h10 + 8'(j), extended_identifier_bits[15:8]);
      rd(8'h18 + 8'(j), extended_identifier_bits[7:0]);
      wr(8'h10 + 8'(j), ~extended_identifier_bits[15:8]);
      rd(8'h10 + 8'(j), extended_identifier_bits[15:8]);
    end
    // buffer 5 set to transmit: id bytes writable, capture ignored
    wr(8'h03, 8'h20);
    rd(8'h03, 8'h20);
    d = 8'($urandom);
    wr(8'h15, d);
    wr(8'h1d, ~d);
    i_eng.load(3'h5, 16'h0000);
    rd(8'h15, d);
    rd(8'h1d, ~d);
    wr(8'h02, 8'h00);
    wr(8'h01, 8'hff);
    rd(8'h15, 8'h00);
    rd(8'h01, 8'h00);
    // reserved mode code leaves legacy mode in place
    wr(8'h02, 8'h03);
    rd(8'h02, 8'h00);
    rd(8'hff, 8'h00);
    complete_run;
  end
endmodule // test_crf_rx_buffer_filter_select
bind crf_rx_buffer_filter_select crf_assertions i_chk (.*);
`default_nettype wire
